// ---- design/mca_decide.sv ----
/*
  Per-access decision logic: store allocation, transient selection and the
  user-mode cache-locking exception checks.
  Assumes controls come from the register and page attributes from the
  translation buffer entry of the current access.
*/
`timescale 1ns/1ps
module mca_decide
  import mca_pkg::*;
(
  input wire logic store_alloc_inhibit,
  input wire logic transient_attr_enable,
  input wire logic page_alloc_ctrl_enable,
  input wire logic dflush_lock_exc_enable,
  input wire logic iinval_lock_exc_enable,
  input wire logic page_attr_one,
  input wire logic page_attr_two,
  input wire logic page_write_through,
  input wire logic problem_state_bit,
  input wire logic dflush_exec,
  input wire logic iinval_exec,
  output logic store_allocate,
  output logic store_write_cache,
  output logic store_write_memory,
  output logic use_transient,
  output logic lock_exception
);

  // The allocate source is either the page attribute or the global bit.
  always_comb begin
    if (page_alloc_ctrl_enable) begin
      store_allocate = ~page_attr_two;
    end else begin
      store_allocate = ~store_alloc_inhibit;
    end
    store_write_cache = store_allocate;
    // Without allocation memory takes the data whatever write-through says.
    store_write_memory = ~store_allocate | page_write_through;
    use_transient = transient_attr_enable & page_attr_one;
    // Raised before the lock state of the line is known; supervisor never traps.
    lock_exception = problem_state_bit & ((dflush_exec & dflush_lock_exc_enable) |
                     (iinval_exec & iinval_lock_exc_enable));
  end

endmodule

// ---- design/mca_pkg.sv ----
/*
  Package for the memory-management control register block: bit positions
  (big-endian numbering converted to vector indices), reset value and the
  special-register move commands.
  Assumes a 32-bit general-purpose register data path.
*/
package mca_pkg;

  localparam int MCA_WIDTH = 32;

  // Big-endian bit n sits at vector index 31-n.
  localparam int MCA_STORE_ALLOC_INHIBIT_BIT = 31 - 7;
  localparam int MCA_TRANSIENT_ATTR_ENABLE_BIT = 31 - 9;
  localparam int MCA_PAGE_ALLOC_CTRL_ENABLE_BIT = 31 - 10;
  localparam int MCA_DFLUSH_LOCK_EXC_ENABLE_BIT = 31 - 12;
  localparam int MCA_IINVAL_LOCK_EXC_ENABLE_BIT = 31 - 13;
  localparam int MCA_SEARCH_SPACE_BIT = 31 - 15;
  localparam int MCA_SEARCH_IDENT_LSB = 31 - 31;
  localparam int MCA_SEARCH_IDENT_WIDTH = 8;

  // Writable bits; every reserved position reads zero.
  localparam logic [31:0] MCA_WRITE_MASK = 32'h016D00FF;
  localparam logic [31:0] MCA_RESET_VALUE = 32'h00000000;

  // Move command carried on the special-register port.
  typedef enum logic [1:0] {
    MCA_CMD_IDLE = 2'b00,
    MCA_CMD_MOVE_TO = 2'b01,
    MCA_CMD_MOVE_FROM = 2'b10
  } mca_cmd_t;

endpackage

// ---- design/mca_top.sv ----
/*
  Memory-management control register with its store-allocate, transient,
  lock-exception and translation-search controls.
  Assumes the pipeline presents one move or buffer command per cycle,
  synchronous to core_clk.
*/
// Summary of operation
// - Bit 7 clear lets cacheable store misses allocate, set stops allocation.
// - With bit 10 set the page attribute two decides allocation and bit 7 is ignored.
// - With bit 10 clear bit 7 governs allocation for every cacheable store miss.
// - Allocating misses fill the line and write cache, plus memory if write-through.
// - Non-allocating misses write memory only, whatever write-through says.
// - Bit 9 enables page attribute one as the transient selector.
// - Bit 12 set makes a user-mode data flush raise a cache-locking exception.
// - Bit 13 set makes a user-mode instruction invalidate raise the same exception.
// - Bit 15 gives the space value compared by a buffer search.
// - Bits 24:31 give the identifier compared by a buffer search.
// - Bits 24:31 are loaded by buffer read and written into the entry on buffer write.
// - With transient enabled, attribute one at 1 uses the transient portion.
// - With page control enabled, attribute two at 0 allocates, otherwise not.
// - User mode means the problem-state bit is 1; supervisor always proceeds.
// - Software writes the register by move-to and reads it by move-from.
`timescale 1ns/1ps
module mca_top
  import mca_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire mca_cmd_t spr_cmd,
  input wire logic [MCA_WIDTH-1:0] spr_wdata,
  output logic [MCA_WIDTH-1:0] spr_rdata,
  input wire logic buf_read_exec,
  input wire logic [MCA_SEARCH_IDENT_WIDTH-1:0] buf_read_ident,
  input wire logic buf_write_exec,
  output logic [MCA_SEARCH_IDENT_WIDTH-1:0] entry_ident,
  output logic search_space,
  output logic [MCA_SEARCH_IDENT_WIDTH-1:0] search_ident,
  input wire logic page_attr_one,
  input wire logic page_attr_two,
  input wire logic page_write_through,
  input wire logic problem_state_bit,
  input wire logic dflush_exec,
  input wire logic iinval_exec,
  output logic store_allocate,
  output logic store_write_cache,
  output logic store_write_memory,
  output logic use_transient,
  output logic lock_exception
);

  // ****************************************
  // Reset release
  // ****************************************

  logic rst_meta_q;
  logic rst_sync_q;

  // Two stages so that release never lands mid-setup on the register.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ****************************************
  // Control register
  // ****************************************

  logic [MCA_WIDTH-1:0] ctrl_q;
  logic [MCA_WIDTH-1:0] ctrl_d;
  logic [MCA_WIDTH-1:0] rdata_q;
  logic [MCA_WIDTH-1:0] rdata_d;

  // A move-to takes the masked word; a buffer read overwrites the identifier
  // field and wins if both arrive together since it is the later pipe stage.
  always_comb begin
    ctrl_d = ctrl_q;
    if (spr_cmd == MCA_CMD_MOVE_TO) begin
      ctrl_d = spr_wdata & MCA_WRITE_MASK;
    end
    if (buf_read_exec) begin
      ctrl_d[MCA_SEARCH_IDENT_LSB +: MCA_SEARCH_IDENT_WIDTH] = buf_read_ident;
    end
    rdata_d = rdata_q;
    if (spr_cmd == MCA_CMD_MOVE_FROM) begin
      rdata_d = ctrl_q & MCA_WRITE_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ctrl_q <= MCA_RESET_VALUE;
      rdata_q <= MCA_RESET_VALUE;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Search and transfer values come straight from register flops.
  always_comb begin
    spr_rdata = rdata_q;
    search_space = ctrl_q[MCA_SEARCH_SPACE_BIT];
    search_ident = ctrl_q[MCA_SEARCH_IDENT_LSB +: MCA_SEARCH_IDENT_WIDTH];
    entry_ident = ctrl_q[MCA_SEARCH_IDENT_LSB +: MCA_SEARCH_IDENT_WIDTH];
  end

  mca_decide u_decide (
    .store_alloc_inhibit(ctrl_q[MCA_STORE_ALLOC_INHIBIT_BIT]),
    .transient_attr_enable(ctrl_q[MCA_TRANSIENT_ATTR_ENABLE_BIT]),
    .page_alloc_ctrl_enable(ctrl_q[MCA_PAGE_ALLOC_CTRL_ENABLE_BIT]),
    .dflush_lock_exc_enable(ctrl_q[MCA_DFLUSH_LOCK_EXC_ENABLE_BIT]),
    .iinval_lock_exc_enable(ctrl_q[MCA_IINVAL_LOCK_EXC_ENABLE_BIT]),
    .page_attr_one(page_attr_one),
    .page_attr_two(page_attr_two),
    .page_write_through(page_write_through),
    .problem_state_bit(problem_state_bit),
    .dflush_exec(dflush_exec),
    .iinval_exec(iinval_exec),
    .store_allocate(store_allocate),
    .store_write_cache(store_write_cache),
    .store_write_memory(store_write_memory),
    .use_transient(use_transient),
    .lock_exception(lock_exception)
  );

  // ****************************************
  // Assertions
  // ****************************************

  sequence s_move_to;
    spr_cmd == MCA_CMD_MOVE_TO && !buf_read_exec;
  endsequence

  a_alloc_global: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    !ctrl_q[MCA_PAGE_ALLOC_CTRL_ENABLE_BIT] |-> store_allocate == !ctrl_q[MCA_STORE_ALLOC_INHIBIT_BIT])
    else $error("Global allocate choice wrong.");
  a_alloc_page: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    ctrl_q[MCA_PAGE_ALLOC_CTRL_ENABLE_BIT] |-> store_allocate == !page_attr_two)
    else $error("Page allocate choice wrong.");
  a_noalloc_memory: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    !store_allocate |-> store_write_memory && !store_write_cache)
    else $error("Non-allocating store not memory only.");
  a_alloc_wthru: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    store_allocate |-> store_write_cache && store_write_memory == page_write_through)
    else $error("Allocating store path wrong.");
  a_transient_sel: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    use_transient == (ctrl_q[MCA_TRANSIENT_ATTR_ENABLE_BIT] && page_attr_one))
    else $error("Transient selection wrong.");
  a_dflush_trap: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    dflush_exec && problem_state_bit && ctrl_q[MCA_DFLUSH_LOCK_EXC_ENABLE_BIT] |-> lock_exception)
    else $error("Data flush lock exception missed.");
  a_super_free: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    !problem_state_bit |-> !lock_exception)
    else $error("Supervisor access trapped.");
  a_iinval_trap: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    !dflush_exec && iinval_exec && problem_state_bit |-> lock_exception == ctrl_q[MCA_IINVAL_LOCK_EXC_ENABLE_BIT])
    else $error("Invalidate lock exception wrong.");
  a_write_read: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    s_move_to ##1 spr_cmd == MCA_CMD_MOVE_FROM |=> spr_rdata == ($past(spr_wdata, 2) & MCA_WRITE_MASK))
    else $error("Readback does not match masked write.");
  a_read_ident: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    buf_read_exec |=> search_ident == $past(buf_read_ident) && entry_ident == search_ident)
    else $error("Buffer read identifier not loaded.");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    (spr_rdata & ~MCA_WRITE_MASK) == 32'h00000000)
    else $error("Reserved bit reads nonzero.");

endmodule

// ---- tb/mca_tlb_model.sv ----
/*
  Far-side model of one translation buffer entry for the control block.
  Assumes buffer read and write arrive as one-cycle pulses on core_clk.
*/
`timescale 1ns/1ps
module mca_tlb_model
  import mca_pkg::*;
#(
  parameter logic [7:0] INIT_IDENT = 8'h3C
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic buf_write_exec,
  input wire logic [MCA_SEARCH_IDENT_WIDTH-1:0] entry_ident,
  output logic [MCA_SEARCH_IDENT_WIDTH-1:0] buf_read_ident
);
  // ****************
  // Entry identifier
  // ****************
  logic [MCA_SEARCH_IDENT_WIDTH-1:0] ident_q;
  // The entry keeps its identifier until a buffer write replaces it.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ident_q <= INIT_IDENT;
    end else if (buf_write_exec) begin
      ident_q <= entry_ident;
    end
  end
  // Read data is offered at once, kinder than a real array but legal here.
  assign buf_read_ident = ident_q;
endmodule

// ---- tb/tb.sv ----
/*
  Self-checking bench for the control register and its decisions.
  Assumes the design answers moves at the taking edge itself.
*/
`timescale 1ns/1ps
module tb
  import mca_pkg::*;
;
  // *****************
  // Bench environment
  // *****************
  logic core_clk = 0, rst_b = 0, buf_read_exec = 0, buf_write_exec = 0;
  mca_cmd_t spr_cmd = MCA_CMD_IDLE;
  logic [31:0] spr_wdata = 32'h0, spr_rdata, w;
  logic [7:0] buf_read_ident, entry_ident, search_ident;
  logic search_space, st_alloc, st_cache, st_mem, use_tr, lock_exc, alloc;
  logic u1 = 0, u2 = 0, wt = 0, pr = 0, dfl = 0, iinv = 0;
  logic [10:0] v;
  int n_fail = 0, compares = 0;
  mca_top i_dut (.core_clk(core_clk), .rst_b(rst_b), .spr_cmd(spr_cmd), .spr_wdata(spr_wdata),
    .spr_rdata(spr_rdata), .buf_read_exec(buf_read_exec), .buf_read_ident(buf_read_ident),
    .buf_write_exec(buf_write_exec), .entry_ident(entry_ident), .search_space(search_space),
    .search_ident(search_ident), .page_attr_one(u1), .page_attr_two(u2), .page_write_through(wt),
    .problem_state_bit(pr), .dflush_exec(dfl), .iinval_exec(iinv), .store_allocate(st_alloc),
    .store_write_cache(st_cache), .store_write_memory(st_mem), .use_transient(use_tr),
    .lock_exception(lock_exc));
  mca_tlb_model i_tlb (.core_clk(core_clk), .rst_b(rst_b), .buf_write_exec(buf_write_exec),
    .entry_ident(entry_ident), .buf_read_ident(buf_read_ident));
  // Clock at 200 MHz.
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Both moves leave the command idle again so each is taken exactly once.
  task automatic wr(input logic [31:0] d);
    @(posedge core_clk);
    spr_cmd <= MCA_CMD_MOVE_TO;
    spr_wdata <= d;
    @(posedge core_clk);
    spr_cmd <= MCA_CMD_IDLE;
    #1;
  endtask
  task automatic rd(input logic [31:0] exp);
    @(posedge core_clk);
    spr_cmd <= MCA_CMD_MOVE_FROM;
    @(posedge core_clk);
    spr_cmd <= MCA_CMD_IDLE;
    #1;
    chk(spr_rdata, exp);
  endtask
  // A move-from straight after a move-to must already see the new word.
  task automatic wr_rd(input logic [31:0] d, input logic [31:0] exp);
    @(posedge core_clk);
    spr_cmd <= MCA_CMD_MOVE_TO;
    spr_wdata <= d;
    @(posedge core_clk);
    spr_cmd <= MCA_CMD_MOVE_FROM;
    @(posedge core_clk);
    spr_cmd <= MCA_CMD_IDLE;
    #1;
    chk(spr_rdata, exp);
  endtask
  // One-cycle buffer command: a write when to_write is set, a read otherwise.
  task automatic pulse(input logic to_write);
    @(posedge core_clk);
    if (to_write) begin
      buf_write_exec <= 1'b1;
    end else begin
      buf_read_exec <= 1'b1;
    end
    @(posedge core_clk);
    buf_read_exec <= 1'b0;
    buf_write_exec <= 1'b0;
    #1;
  endtask
  task automatic conclude();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // A hang counts as a mismatch and still reaches the verdict.
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    conclude();
  end
  // Main sequence: reset, register map, decision table, buffer transfers.
  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(32'h0);
    wr(32'hFFFFFFFF);
    rd(32'h016D00FF);
    chk(search_space, 1'b1);
    chk(search_ident, 8'hFF);
    wr_rd(32'hA5A5A5A5, 32'h012500A5);
    chk(search_ident, 8'hA5);
    for (int k = 0; k < 2048; k++) begin
      v = k[10:0];
      w = 32'h0;
      w[MCA_STORE_ALLOC_INHIBIT_BIT] = v[0];
      w[MCA_TRANSIENT_ATTR_ENABLE_BIT] = v[1];
      w[MCA_PAGE_ALLOC_CTRL_ENABLE_BIT] = v[2];
      w[MCA_DFLUSH_LOCK_EXC_ENABLE_BIT] = v[3];
      w[MCA_IINVAL_LOCK_EXC_ENABLE_BIT] = v[4];
      @(posedge core_clk);
      {iinv, dfl, pr, wt, u2, u1} <= v[10:5];
      wr(w);
      alloc = v[2] ? !v[6] : !v[0];
      chk(st_alloc, alloc);
      chk(st_cache, alloc);
      chk(st_mem, !alloc || v[7]);
      chk(use_tr, v[1] && v[5]);
      chk(lock_exc, v[8] && ((v[9] && v[3]) || (v[10] && v[4])));
    end
    pulse(1'b0);
    chk(search_ident, 8'h3C);
    chk(entry_ident, 8'h3C);
    wr(32'h0001005A);
    chk(search_space, 1'b1);
    chk(entry_ident, 8'h5A);
    pulse(1'b1);
    chk(i_tlb.ident_q, 8'h5A);
    rd(32'h0001005A);
    conclude();
  end
endmodule
